/* File: testbench/ds3_tx_overhead_insert_port_tb.sv */
`timescale 1ns/1ns
module ds3_tx_overhead_insert_port_tb;
	logic	sys_clk, sys_rst, oh_link_clk, frame_start, ins_en, ins_bit, oh_clk, marker, valid;
	logic	rejected, overrun;
	logic [15:0]	gen_ovh, next_ovh, req_mask, req_data;
	logic [31:0]	lfsr;
	int	num_errors, samples_checked, rej_seen, ov_seen;
	ds3oh_insert ds3oh_insert_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .oh_link_clk(oh_link_clk),
		.overhead_bit_in(ins_bit), .overhead_insert_en(ins_en), .overhead_clk_out(oh_clk),
		.overhead_frame_marker(marker), .frame_start(frame_start), .gen_overhead(gen_ovh),
		.next_overhead(next_ovh), .next_overhead_valid(valid), .insert_rejected(rejected), .insert_overrun(overrun));
	ds3oh_equip_model ds3oh_equip_model_inst (.oh_clk(oh_clk), .frame_marker(marker), .ins_en(ins_en),
		.ins_bit(ins_bit), .req_mask(req_mask), .req_data(req_data));
	initial begin
		sys_clk = 0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		oh_link_clk = 0;
		#3;
		forever begin
			#7 oh_link_clk = 1;
			#8 oh_link_clk = 0;
		end
	end
	always @(posedge sys_clk) if (rejected === 1'b1) rej_seen++;
	always @(posedge sys_clk) if (overrun === 1'b1) ov_seen++;
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	function automatic logic [15:0] exp_ovh(input logic [15:0] m, d, g);
		logic [15:0] k;
		k = m & 16'h5555;
		return (k & d) | (~k & g);
	endfunction
	task check(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one gathered frame, then two back-to-back frame starts
	task run_frame(input logic [15:0] m, d, g);
		@(posedge marker);
		req_mask = m;
		req_data = d;
		rej_seen = 0;
		@(posedge marker);
		req_mask = 16'h0000;
		ov_seen = 0;
		repeat (6) @(posedge sys_clk);
		#1 frame_start = 1;
		gen_ovh = g;
		@(posedge sys_clk);
		#1 gen_ovh = ~g;
		check({15'h0, valid}, 16'h0001);
		check(next_ovh, exp_ovh(m, d, g));
		@(posedge sys_clk);
		#1 frame_start = 0;
		check(next_ovh, ~g);
		check({15'h0, rej_seen != 0}, {15'h0, |(m & 16'haaaa)});
		check(16'(ov_seen), 16'h0001);
		$display("test done mask %h data %h", m, d);
	endtask
	initial begin
		#200000;
		num_errors++;
		stop_test;
	end
	initial begin
		sys_rst = 0;
		frame_start = 0;
		gen_ovh = 16'h0000;
		req_mask = 16'h0000;
		req_data = 16'h0000;
		lfsr = 32'h000030c9;
		num_errors = 0;
		samples_checked = 0;
		rej_seen = 0;
		ov_seen = 0;
		#1 sys_rst = 1;
		repeat (8) @(posedge sys_clk);
		#1 sys_rst = 0;
		run_frame(16'hffff, 16'hffff, 16'h0000);
		run_frame(16'h5555, 16'h0000, 16'hffff);
		run_frame(16'h0000, 16'hffff, 16'h3c5a);
		run_frame(16'h0001, 16'h0001, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			run_frame(lfsr[15:0], lfsr[31:16], lfsr[23:8]);
		end
		stop_test;
	end
endmodule
bind ds3oh_insert ds3oh_insert_sva ds3oh_insert_sva_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.oh_link_clk(oh_link_clk), .overhead_bit_in(overhead_bit_in), .overhead_insert_en(overhead_insert_en),
	.overhead_clk_out(overhead_clk_out), .overhead_frame_marker(overhead_frame_marker),
	.frame_start(frame_start), .gen_overhead(gen_overhead), .next_overhead(next_overhead),
	.next_overhead_valid(next_overhead_valid), .insert_rejected(insert_rejected), .insert_overrun(insert_overrun));

/* File: testbench/ds3oh_equip_model.sv */
`timescale 1ns/1ns
module ds3oh_equip_model (
	// overhead port, seen from the equipment
	input wire logic	oh_clk,
	input wire logic	frame_marker,
	output logic	ins_en,
	output logic	ins_bit,
	// bits wanted for the next frame
	input wire logic [15:0]	req_mask,
	input wire logic [15:0]	req_data
);
	int	cnt = 99;
	logic [15:0]	act_mask = 16'h0000;
	logic [15:0]	act_data = 16'h0000;
	initial ins_en = 1'b0;
	initial ins_bit = 1'b0;
	// launch after the rising edge so data is settled at the falling edge
	always @(posedge oh_clk) begin
		if (frame_marker) begin
			cnt = 0;
			act_mask = req_mask;
			act_data = req_data;
		end else if (cnt < 99) begin
			cnt = cnt + 1;
		end
		if (cnt < 16 && act_mask[cnt]) begin
			ins_en <= 1'b1;
			ins_bit <= act_data[cnt];
		end else begin
			ins_en <= 1'b0;
			ins_bit <= ~ins_bit;
		end
	end
endmodule

/* File: testbench/ds3oh_insert_sva.sv */
`timescale 1ns/1ns
module ds3oh_insert_sva (
	// clocks and reset
	input wire logic	sys_clk,
	input wire logic	sys_rst,
	input wire logic	oh_link_clk,
	// pins
	input wire logic	overhead_bit_in,
	input wire logic	overhead_insert_en,
	input wire logic	overhead_clk_out,
	input wire logic	overhead_frame_marker,
	// framer side
	input wire logic	frame_start,
	input wire logic [15:0]	gen_overhead,
	input wire logic [15:0]	next_overhead,
	input wire logic	next_overhead_valid,
	input wire logic	insert_rejected,
	input wire logic	insert_overrun
);
	logic [5:0]	gap_reg, gap_next;
	logic	seen_reg, seen_next;
	// link periods since the marker was last seen
	always_comb begin
		gap_next = overhead_frame_marker ? 6'h00 : gap_reg + 6'h01;
		seen_next = seen_reg | overhead_frame_marker;
	end
	always_ff @(posedge oh_link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_reg <= 6'h00;
			seen_reg <= 1'h0;
		end else begin
			gap_reg <= gap_next;
			seen_reg <= seen_next;
		end
	end
	a_valid_after_start: assert property (@(posedge sys_clk) disable iff (sys_rst) frame_start |=> next_overhead_valid)
		else $error("no valid after frame start");
	a_valid_has_cause: assert property (@(posedge sys_clk) disable iff (sys_rst) next_overhead_valid |-> $past(frame_start))
		else $error("valid without frame start");
	a_framing_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
		next_overhead_valid |-> ((next_overhead ^ $past(gen_overhead)) & 16'haaaa) == 16'h0000)
		else $error("framing bit replaced");
	a_word_held: assert property (@(posedge sys_clk) disable iff (sys_rst) !frame_start |=> $stable(next_overhead))
		else $error("word changed without frame start");
	a_overrun_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) insert_overrun |=> !insert_overrun)
		else $error("overrun not a pulse");
	a_marker_single: assert property (@(posedge oh_link_clk) disable iff (sys_rst) overhead_frame_marker |=> !overhead_frame_marker)
		else $error("marker longer than one period");
	a_marker_period: assert property (@(posedge oh_link_clk) disable iff (sys_rst)
		overhead_frame_marker && seen_reg |-> gap_reg == 6'h37)
		else $error("marker spacing wrong");
	a_clk_forward: assert property (@(posedge sys_clk) disable iff (sys_rst) overhead_clk_out == oh_link_clk)
		else $error("overhead clock not forwarded");
	a_reset_quiet: assert property (@(posedge sys_clk) sys_rst |-> !overhead_frame_marker && next_overhead == 16'h0000)
		else $error("outputs active in reset");
	c_reject: cover property (@(posedge sys_clk) insert_rejected);
	c_overrun: cover property (@(posedge sys_clk) insert_overrun);
	c_valid: cover property (@(posedge sys_clk) next_overhead_valid);
endmodule

/* File: verilog/ds3oh_insert.sv */
`timescale 1ns/1ns
`include "ds3oh_params.svh"

// Operation
// - two feeding methods exist; this block implements the overhead-clock-output method.
// - overhead data input is latched on the falling edge of the overhead clock.
// - accepted bits go to matching overhead positions of the outbound stream via framer.
// - count 0 is the marker-high edge, first X bit, insertable.
// - odd counts 1 to 15 are framing bits and refuse insertion.
// - counts 2, 4, 6 carry insertable C11, C12, C13.
// - count 8 second X bit; 10, 12, 14 carry C21-C23; all insertable.
// - insert enable high samples data; low keeps internally generated overhead.
// - insertion attempts on non-insertable positions are ignored.
// - frame marker pulses high while the last overhead bit is handled.
// - accepted overhead goes into the very next outbound frame; here a frame arriving with frame_start waits for the one after.
module ds3oh_insert (
	// system clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// link clock
	input  wire logic                   oh_link_clk,
	// overhead insertion pins
	input  wire logic                   overhead_bit_in,
	input  wire logic                   overhead_insert_en,
	output logic                        overhead_clk_out,
	output logic                        overhead_frame_marker,
	// transmit framer side
	input  wire logic                   frame_start,
	input  wire logic [15:0]            gen_overhead,
	output logic [15:0]                 next_overhead,
	output logic                        next_overhead_valid,
	output logic                        insert_rejected,
	output logic                        insert_overrun
);
	import ds3oh_pkg::*;

	// ************************************************
	// link-facing logic
	// ************************************************
	ds3oh_ovr_type               frame_ovr;
	ds3oh_evt_type               link_evt;

	// the overhead clock is the link clock forwarded to the pin
	assign overhead_clk_out = oh_link_clk;

	ds3oh_link u_link (
		.link_clk              (oh_link_clk),
		.sys_rst               (sys_rst),
		.overhead_bit_in       (overhead_bit_in),
		.overhead_insert_en    (overhead_insert_en),
		.overhead_frame_marker (overhead_frame_marker),
		.frame_ovr             (frame_ovr),
		.link_evt              (link_evt)
	);

	// ************************************************
	// event toggle synchronisers
	// ************************************************
	ds3oh_evt_type               evt_meta_reg;
	ds3oh_evt_type               evt_sync_reg;
	ds3oh_evt_type               evt_prev_reg;
	logic                        frame_evt;
	logic                        reject_evt;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_meta_reg <= '0;
			evt_sync_reg <= '0;
			evt_prev_reg <= '0;
		end else begin
			evt_meta_reg <= link_evt;
			evt_sync_reg <= evt_meta_reg;
			evt_prev_reg <= evt_sync_reg;
		end
	end

	assign frame_evt  = evt_sync_reg.frame_tgl ^ evt_prev_reg.frame_tgl;
	assign reject_evt = evt_sync_reg.reject_tgl ^ evt_prev_reg.reject_tgl;

	// ************************************************
	// pending overhead and merge into the next frame
	// ************************************************
	ds3oh_ovr_type               pend_reg;
	ds3oh_ovr_type               pend_next;
	logic                        pend_full_reg;
	logic                        pend_full_next;
	logic [15:0]                 next_oh_reg;
	logic [15:0]                 next_oh_next;
	logic                        valid_reg;
	logic                        valid_next;
	logic                        reject_reg;
	logic                        reject_next;
	logic                        overrun_reg;
	logic                        overrun_next;

	always_comb begin
		pend_next      = pend_reg;
		pend_full_next = pend_full_reg;
		next_oh_next   = next_oh_reg;
		valid_next     = 1'h0;
		reject_next    = reject_evt;
		overrun_next   = 1'h0;
		if (frame_start) begin
			// untaken positions keep the internally generated overhead
			next_oh_next   = (gen_overhead & ~pend_reg.mask) | (pend_reg.data & pend_reg.mask);
			valid_next     = 1'h1;
			pend_next      = '0;
			pend_full_next = 1'h0;
		end
		// a frame arriving together with frame_start is kept for the next one
		if (frame_evt) begin
			pend_next      = frame_ovr;
			pend_full_next = 1'h1;
			overrun_next   = pend_full_reg && !frame_start;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_reg      <= '0;
			pend_full_reg <= `DS3OH_BIT_RST;
			next_oh_reg   <= `DS3OH_WORD_RST;
			valid_reg     <= `DS3OH_BIT_RST;
			reject_reg    <= `DS3OH_BIT_RST;
			overrun_reg   <= `DS3OH_BIT_RST;
		end else begin
			pend_reg      <= pend_next;
			pend_full_reg <= pend_full_next;
			next_oh_reg   <= next_oh_next;
			valid_reg     <= valid_next;
			reject_reg    <= reject_next;
			overrun_reg   <= overrun_next;
		end
	end

	assign next_overhead       = next_oh_reg;
	assign next_overhead_valid = valid_reg;
	assign insert_rejected     = reject_reg;
	assign insert_overrun      = overrun_reg;

endmodule

/* File: verilog/ds3oh_link.sv */
`timescale 1ns/1ns
`include "ds3oh_params.svh"

module ds3oh_link (
	// link clock and reset
	input  wire logic                   link_clk,
	input  wire logic                   sys_rst,
	// pins
	input  wire logic                   overhead_bit_in,
	input  wire logic                   overhead_insert_en,
	output logic                        overhead_frame_marker,
	// towards the system domain
	output ds3oh_pkg::ds3oh_ovr_type    frame_ovr,
	output ds3oh_pkg::ds3oh_evt_type    link_evt
);
	import ds3oh_pkg::*;

	// ************************************************
	// reset release synchroniser
	// ************************************************
	logic                        rst_meta_reg;
	logic                        rst_sync_reg;

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_meta_reg <= 1'h1;
			rst_sync_reg <= 1'h1;
		end else begin
			rst_meta_reg <= 1'h0;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ************************************************
	// position counter and frame marker (rising edge)
	// ************************************************
	logic [`DS3OH_POS_W-1:0]     pos_reg;
	logic [`DS3OH_POS_W-1:0]     pos_next;
	logic                        marker_reg;
	logic                        marker_next;

	always_comb begin
		if (pos_reg == `DS3OH_LAST_POS) begin
			pos_next = '0;
		end else begin
			pos_next = pos_reg + 6'h01;
		end
		marker_next = (pos_next == `DS3OH_LAST_POS);
	end

	always_ff @(posedge link_clk or posedge rst_sync_reg) begin
		if (rst_sync_reg) begin
			pos_reg    <= `DS3OH_POS_RST;
			marker_reg <= `DS3OH_BIT_RST;
		end else begin
			pos_reg    <= pos_next;
			marker_reg <= marker_next;
		end
	end

	assign overhead_frame_marker = marker_reg;

	// ************************************************
	// overhead capture (falling edge)
	// ************************************************
	ds3oh_ovr_type               shadow_reg;
	ds3oh_ovr_type               shadow_next;
	ds3oh_ovr_type               hold_reg;
	ds3oh_ovr_type               hold_next;
	ds3oh_evt_type               evt_reg;
	ds3oh_evt_type               evt_next;
	logic                        rej_frame_reg;
	logic                        rej_frame_next;
	logic                        tracked;
	logic [3:0]                  idx;

	// insertable positions among the tracked ones
	localparam logic [15:0]      ins_mask = `DS3OH_INS_MASK;

	always_comb begin
		shadow_next    = shadow_reg;
		hold_next      = hold_reg;
		evt_next       = evt_reg;
		rej_frame_next = rej_frame_reg;
		tracked        = (pos_reg < 6'(`DS3OH_TRACKED));
		idx            = pos_reg[3:0];
		if (overhead_insert_en) begin
			if (tracked && ins_mask[idx]) begin
				shadow_next.mask[idx] = 1'h1;
				shadow_next.data[idx] = overhead_bit_in;
			end else begin
				rej_frame_next = 1'h1;
			end
		end
		if (pos_reg == `DS3OH_LAST_POS) begin
			hold_next          = shadow_next;
			evt_next.frame_tgl = ~evt_reg.frame_tgl;
			// at most one reject toggle per frame, so the slower side never sees a pair cancel
			evt_next.reject_tgl = evt_reg.reject_tgl ^ rej_frame_next;
			shadow_next        = '0;
			rej_frame_next     = 1'h0;
		end
	end

	always_ff @(negedge link_clk or posedge rst_sync_reg) begin
		if (rst_sync_reg) begin
			shadow_reg    <= '0;
			hold_reg      <= '0;
			evt_reg       <= '0;
			rej_frame_reg <= `DS3OH_BIT_RST;
		end else begin
			shadow_reg    <= shadow_next;
			hold_reg      <= hold_next;
			evt_reg       <= evt_next;
			rej_frame_reg <= rej_frame_next;
		end
	end

	assign frame_ovr = hold_reg;
	assign link_evt  = evt_reg;

endmodule

/* File: verilog/ds3oh_params.svh */
`ifndef DS3OH_PARAMS_SVH
`define DS3OH_PARAMS_SVH

// ************************************************
// overhead sequence geometry
// ************************************************
`define DS3OH_FRAME_BITS   56
`define DS3OH_POS_W        6
`define DS3OH_TRACKED      16
`define DS3OH_LAST_POS     6'h37
`define DS3OH_INS_MASK     16'h5555

// ************************************************
// reset values
// ************************************************
`define DS3OH_POS_RST      6'h37
`define DS3OH_WORD_RST     16'h0000
`define DS3OH_BIT_RST      1'h0

`endif

/* File: verilog/ds3oh_pkg.sv */
package ds3oh_pkg;

	// overhead bits gathered over one frame: which positions were taken and their values
	typedef struct packed {
		logic [15:0] mask;
		logic [15:0] data;
	} ds3oh_ovr_type;

	// link-domain activity seen by the system side
	typedef struct packed {
		logic frame_tgl;
		logic reject_tgl;
	} ds3oh_evt_type;

endpackage
